// >>> rtl/rsl_pkg.sv
// Purpose: Shared constants and carriers for the ramp/status logger register bank
// Assumes: Command codes are byte-wide; block reads return a flat vector
// Notes: Timing counts derive from the 125 MHz system clock
package rsl_pkg;
   localparam logic [7:0] CMD_SHARE_THR = 8'hDA;
   localparam logic [7:0] CMD_RAMP_LOG = 8'hDB;
   localparam logic [7:0] CMD_TEMP_SEL = 8'hDC;
   localparam logic [7:0] CMD_VIN_OFS = 8'hDD;
   localparam logic [7:0] CMD_VOUT_TRIM = 8'hDE;
   localparam logic [7:0] CMD_STATUS_LOG = 8'hDF;
   localparam int THR_LSB = 0;
   localparam int THR_W = 48;
   localparam int SHARE_EN_BIT = 56;
   localparam int TEMP_SEL_BIT = 0;
   localparam int RAMP_PAIRS = 15;
   localparam int STATUS_WORDS = 16;
   localparam int CNT_W = 16;
   localparam int SAMPLE_W = 8;
   localparam int STATUS_W = 16;
   localparam int BLOCK_W = 256;
   localparam int CLK_MHZ = 125;
   localparam int SNAP_INTERVAL_S = 8;
   localparam int SNAP_WINDOW_S = 128;
   localparam longint SNAP_CYCLES = longint'(SNAP_INTERVAL_S) * 64'd1000000 * CLK_MHZ;
   localparam logic [63:0] SHARE_THR_RESET = 64'h0000000000000000;
   localparam logic [7:0] TEMP_SEL_RESET = 8'h00;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] cmd;
      logic [63:0] wdata;
   } rsl_req_s;

   typedef struct packed {
      logic [SAMPLE_W-1:0] vin;
      logic [SAMPLE_W-1:0] vout;
   } rsl_pair_s;
endpackage

// >>> rtl/rsl_tick.sv
// Purpose: Free divider giving one pulse per period
// Assumes: Enable freezes the count
// Notes: PERIOD may be shortened in simulation
`timescale 1ns/1ps
module rsl_tick #(
   parameter longint PERIOD = 1000
) (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_run,
   output logic o_tick
);
   localparam int W = $clog2(PERIOD + 1);
   logic [W-1:0] cnt;

   // Elaboration check: a zero period would never tick
   if (PERIOD < 1) begin : g_bad_period
      $error("rsl_tick period must be at least one");
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn || !i_run) begin
         cnt <= '0;
         o_tick <= 1'b0;
      end else if (i_ce) begin
         o_tick <= (cnt == W'(PERIOD - 1));
         cnt <= (cnt == W'(PERIOD - 1)) ? '0 : cnt + 1'b1;
      end
   end
endmodule

// >>> rtl/rsl_regs.sv
// Purpose: Manufacturer command bank: share threshold, loggers, trims
// Assumes: Host framing decoded elsewhere into one-cycle command strobes
// Notes: Read data is registered and valid one cycle after the strobe
`timescale 1ns/1ps
// Contract
// - Bit 56 of share threshold enables active current sharing.
// - Share threshold is 8-byte read/write, bits 47:0 threshold level.
// - Ramp log reads 32 bytes: counter 15:0, Vin/Vout pairs above.
// - Fifteen Vin/Vout pairs captured during ramp, spaced by one fifteenth of ramp duration.
// - Counter stored before ramp equals last snapshot count plus one.
// - Only the first ramp after power-up is recorded.
// - Successful ramp-up clears the recorded ramp data.
// - Temp select bit 0: internal sensor 0, external sensor 1.
// - Input offset block: on offset 31:16, off offset 15:0.
// - Output trim readback is a signed 16-bit word.
// - Status log reads sixteen 16-bit words, word n at 16n.
// - Status words captured every 8 s from ramp end for 128 s.
module rsl_regs
   import rsl_pkg::*;
#(
   parameter longint SNAP_PERIOD = rsl_pkg::SNAP_CYCLES,
   parameter int RAMP_T_W = 32
) (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire rsl_pkg::rsl_req_s i_req,
   input wire logic i_ramp_start,
   input wire logic i_ramp_good,
   input wire logic [RAMP_T_W-1:0] i_ramp_cycles,
   input wire logic [7:0] i_vin,
   input wire logic [7:0] i_vout,
   input wire logic [15:0] i_status_word,
   input wire logic [31:0] i_vin_offset,
   input wire logic [15:0] i_vout_trim,
   output logic [255:0] o_rdata,
   output logic o_rvalid,
   output logic o_share_en,
   output logic [47:0] o_share_thr,
   output logic o_temp_ext
);
   import rsl_pkg::*;

   // Elaboration check: the ramp timer must be at least five bits wide
   if (RAMP_T_W < 5) begin : g_bad_ramp_w
      $error("ramp time width too small");
   end

   typedef enum {ST_IDLE, ST_RAMP, ST_LOG, ST_DONE} rsl_state_e;
   rsl_state_e state;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [63:0] share_thr;
   logic [7:0] temp_sel;
   rsl_pair_s pairs [RAMP_PAIRS];
   logic [STATUS_W-1:0] words [STATUS_WORDS];
   logic [CNT_W-1:0] ramp_cnt;
   logic [CNT_W-1:0] snap_count;
   logic [4:0] pair_idx;
   logic [4:0] word_idx;
   logic [RAMP_T_W-1:0] ramp_tmr;
   logic ramp_seen;

   wire wr_thr = i_req.wr && (i_req.cmd == CMD_SHARE_THR);
   wire wr_tsel = i_req.wr && (i_req.cmd == CMD_TEMP_SEL);
   // Interval rounds down so the fifteenth sample lands at or before ramp end
   wire [RAMP_T_W-1:0] interval = i_ramp_cycles / RAMP_T_W'(RAMP_PAIRS);
   wire [RAMP_T_W-1:0] interval_m1 = (interval == '0) ? '0 : interval - 1'b1;
   wire take_pair = (state == ST_RAMP) && (ramp_tmr == interval_m1) && (pair_idx < 5'(RAMP_PAIRS));
   logic snap_tick;

   rsl_tick #(.PERIOD(SNAP_PERIOD)) u_tick (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_ce(i_ce),
      .i_run(state == ST_LOG),
      .o_tick(snap_tick)
   );

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         share_thr <= SHARE_THR_RESET;
         temp_sel <= TEMP_SEL_RESET;
      end else if (i_ce) begin
         if (wr_thr) share_thr <= i_req.wdata;
         if (wr_tsel) temp_sel <= i_req.wdata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Ramp and status capture
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         state <= ST_IDLE;
         ramp_seen <= 1'b0;
         ramp_cnt <= '0;
         snap_count <= '0;
         pair_idx <= '0;
         word_idx <= '0;
         ramp_tmr <= '0;
         for (int i = 0; i < RAMP_PAIRS; i++) pairs[i] <= '0;
         for (int i = 0; i < STATUS_WORDS; i++) words[i] <= '0;
      end else if (i_ce) begin
         case (state)
            ST_IDLE: begin
               if (i_ramp_start && !ramp_seen) begin
                  ramp_seen <= 1'b1;
                  ramp_cnt <= snap_count + 1'b1;
                  pair_idx <= '0;
                  ramp_tmr <= '0;
                  state <= ST_RAMP;
               end
            end
            ST_RAMP: begin
               ramp_tmr <= take_pair ? '0 : ramp_tmr + 1'b1;
               if (take_pair) begin
                  pairs[pair_idx[3:0]] <= '{vin: i_vin, vout: i_vout};
                  pair_idx <= pair_idx + 1'b1;
               end
               if (i_ramp_good) begin
                  // Log kept only while the ramp is unfinished or failed
                  for (int i = 0; i < RAMP_PAIRS; i++) pairs[i] <= '0;
                  ramp_cnt <= '0;
                  word_idx <= '0;
                  state <= ST_LOG;
               end
            end
            ST_LOG: begin
               if (snap_tick) begin
                  words[word_idx[3:0]] <= i_status_word;
                  snap_count <= snap_count + 1'b1;
                  word_idx <= word_idx + 1'b1;
                  if (word_idx == 5'(STATUS_WORDS - 1)) state <= ST_DONE;
               end
            end
            ST_DONE: state <= ST_DONE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [255:0] ramp_blk;
   logic [255:0] stat_blk;
   always_comb begin
      ramp_blk = '0;
      ramp_blk[15:0] = ramp_cnt;
      for (int n = 0; n < RAMP_PAIRS; n++) begin
         ramp_blk[16 + 16*n +: 8] = pairs[n].vin;
         ramp_blk[24 + 16*n +: 8] = pairs[n].vout;
      end
      stat_blk = '0;
      for (int n = 0; n < STATUS_WORDS; n++) stat_blk[16*n +: 16] = words[n];
   end

   // Config outputs lag the write by one flop so every output is registered
   logic [255:0] next_rdata;
   always_comb begin
      case (i_req.cmd)
         CMD_SHARE_THR: next_rdata = {192'h0, share_thr};
         CMD_RAMP_LOG: next_rdata = ramp_blk;
         CMD_TEMP_SEL: next_rdata = {248'h0, temp_sel};
         CMD_VIN_OFS: next_rdata = {224'h0, i_vin_offset};
         CMD_VOUT_TRIM: next_rdata = {240'h0, i_vout_trim};
         CMD_STATUS_LOG: next_rdata = stat_blk;
         default: next_rdata = '0;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_rdata <= '0;
         o_rvalid <= 1'b0;
         o_share_en <= 1'b0;
         o_share_thr <= '0;
         o_temp_ext <= 1'b0;
      end else if (i_ce) begin
         o_rvalid <= i_req.rd;
         if (i_req.rd) o_rdata <= next_rdata;
         o_share_en <= share_thr[SHARE_EN_BIT];
         o_share_thr <= share_thr[THR_LSB +: THR_W];
         o_temp_ext <= temp_sel[TEMP_SEL_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_SHARE_EN: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && wr_thr ##1 i_ce |=> o_share_en == $past(i_req.wdata[SHARE_EN_BIT], 2))
      else $error("share enable mismatch");
   AST_TEMP_SEL: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && wr_tsel ##1 i_ce |=> o_temp_ext == $past(i_req.wdata[0], 2))
      else $error("temp select mismatch");
   AST_RVALID: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && i_req.rd && i_req.cmd == CMD_STATUS_LOG |=> o_rvalid && o_rdata == $past(stat_blk))
      else $error("status read mismatch");
   AST_RAMP_CNT: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && state == ST_IDLE && i_ramp_start && !ramp_seen |=> ramp_cnt == $past(snap_count) + 16'h0001)
      else $error("ramp counter wrong");
   AST_ONE_RAMP: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && ramp_seen && state != ST_RAMP |=> state != ST_RAMP)
      else $error("second ramp recorded");
   AST_CLEAR: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && state == ST_RAMP && i_ramp_good |=> ramp_cnt == 16'h0000 && state == ST_LOG)
      else $error("ramp data not cleared");
   AST_PAIRS: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      pair_idx <= 5'h0F)
      else $error("too many pairs");
   AST_WORDS: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && state == ST_LOG && snap_tick |=> snap_count == $past(snap_count) + 16'h0001)
      else $error("snapshot not counted");
   AST_LOG_STOP: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && state == ST_DONE |=> $stable(snap_count))
      else $error("snapshot taken after log window");
endmodule

// >>> verif/rsl_host.sv
// Purpose: Host model issuing command writes and reads
// Assumes: Request driven after the first edge and taken at the next; read data sampled 1 ns after that same edge
// Notes: Released cmd and wdata lines carry the inverse of the last value; wr and rd return low
`timescale 1ns/1ps
module rsl_host (
   input wire logic i_clk_sys,
   input wire logic i_rvalid,
   input wire logic [255:0] i_rdata,
   output rsl_pkg::rsl_req_s o_req
);
   import rsl_pkg::*;
   initial o_req = '0;
   task automatic wr(input logic [7:0] c, input logic [63:0] d);
      @(posedge i_clk_sys) #1;
      o_req.wr = 1'b1;
      o_req.cmd = c;
      o_req.wdata = d;
      @(posedge i_clk_sys) #1;
      o_req.wr = 1'b0;
      o_req.cmd = ~c;
      o_req.wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] c, output logic [255:0] d, output logic ok);
      @(posedge i_clk_sys) #1;
      o_req.rd = 1'b1;
      o_req.cmd = c;
      @(posedge i_clk_sys) #1;
      o_req.rd = 1'b0;
      o_req.cmd = ~c;
      ok = i_rvalid;
      d = i_rdata;
   endtask
endmodule

// >>> verif/test_rsl_regs.sv
// Purpose: Self-checking bench for the logger command bank
// Assumes: Snapshot period shortened to 20 cycles
// Notes: Inputs change 1 ns after the rising edge, the vin change in t_ramp and the last st change included
`timescale 1ns/1ps
module test_rsl_regs;
   import rsl_pkg::*;
   logic clk, rst_n, r_start, r_good, rv, sh_en, t_ext, ce;
   logic [7:0] vin, vout;
   logic [15:0] st, trim;
   logic [31:0] r_cyc, vofs;
   logic [47:0] thr;
   logic [255:0] rdat, e, d;
   rsl_req_s req;
   int n_errors, check_count, cyc;
   rsl_regs #(.SNAP_PERIOD(20), .RAMP_T_W(32)) dut (.i_clk_sys(clk), .i_resetn(rst_n), .i_ce(ce),
      .i_req(req), .i_ramp_start(r_start), .i_ramp_good(r_good), .i_ramp_cycles(r_cyc), .i_vin(vin),
      .i_vout(vout), .i_status_word(st), .i_vin_offset(vofs), .i_vout_trim(trim), .o_rdata(rdat),
      .o_rvalid(rv), .o_share_en(sh_en), .o_share_thr(thr), .o_temp_ext(t_ext));
   rsl_host host (.i_clk_sys(clk), .i_rvalid(rv), .i_rdata(rdat), .o_req(req));
   task automatic check(input string w, input logic [255:0] s, input logic [255:0] x);
      check_count++;
      if (s !== x) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", w, x, s);
      end
   endtask
   task automatic rd_get(input logic [7:0] c, output logic [255:0] v);
      logic ok;
      host.rd(c, v, ok);
      check("rvalid", ok, 1'b1);
   endtask
   task automatic rd_chk(input string w, input logic [7:0] c, input logic [255:0] x);
      logic [255:0] v;
      rd_get(c, v);
      check(w, v, x);
   endtask
   task automatic pulse(ref logic s);
      @(posedge clk) #1;
      s = 1'b1;
      @(posedge clk) #1;
      s = 1'b0;
   endtask
   task automatic t_share;
      host.wr(CMD_SHARE_THR, 64'h7F01_BEEF_1234_5678);
      repeat (3) @(posedge clk) #1;
      check("share_en", sh_en, 1'b1);
      check("thr", thr, 48'hBEEF_1234_5678);
      rd_chk("thr_rd", CMD_SHARE_THR, 64'h7F01_BEEF_1234_5678);
      host.wr(CMD_SHARE_THR, 64'h0000_0000_0000_0001);
      repeat (3) @(posedge clk) #1;
      check("share_off", sh_en, 1'b0);
      // Write while the enable is low must not land
      ce = 1'b0;
      host.wr(CMD_SHARE_THR, 64'h0100_0000_0000_00FF);
      ce = 1'b1;
      repeat (3) @(posedge clk) #1;
      check("frozen", {sh_en, thr}, {1'b0, 48'h0000_0000_0001});
   endtask
   task automatic t_temp;
      for (int b = 1; b >= 0; b--) begin
         host.wr(CMD_TEMP_SEL, 64'h80 | b);
         repeat (3) @(posedge clk) #1;
         check("temp_ext", t_ext, b[0]);
         rd_chk("temp_rd", CMD_TEMP_SEL, 8'h80 | b);
      end
   endtask
   task automatic t_trim;
      rd_chk("vin_ofs", CMD_VIN_OFS, 32'hAB12_34CD);
      rd_chk("vout_trim", CMD_VOUT_TRIM, 16'hF00D);
      rd_chk("unmapped", 8'hE0, 256'h0);
   endtask
   task automatic t_ramp;
      e = 256'h1;
      for (int n = 0; n < 15; n++) begin
         e[16+16*n +: 16] = 16'hA55A;
      end
      pulse(r_start);
      repeat (40) @(posedge clk);
      rd_chk("ramp", CMD_RAMP_LOG, e);
      vin = 8'h11;
      pulse(r_start);
      repeat (40) @(posedge clk);
      rd_chk("ramp2", CMD_RAMP_LOG, e);
   endtask
   task automatic t_status;
      pulse(r_good);
      rd_chk("ramp_clr", CMD_RAMP_LOG, 256'h0);
      repeat (60) @(posedge clk) #1;
      st = 16'hB00B;
      repeat (400) @(posedge clk);
      rd_get(CMD_STATUS_LOG, d);
      check("word0", d[15:0], 16'hC001);
      check("word15", d[255:240], 16'hB00B);
      st = 16'h0DD0;
      repeat (100) @(posedge clk);
      rd_get(CMD_STATUS_LOG, d);
      check("stopped", d[255:240], 16'hB00B);
      // A later ramp in the same power cycle must leave the cleared log alone
      pulse(r_start);
      repeat (40) @(posedge clk) #1;
      rd_chk("ramp3", CMD_RAMP_LOG, 256'h0);
   endtask
   task automatic t_power;
      @(posedge clk) #1;
      rst_n = 1'b0;
      repeat (2) @(posedge clk) #1;
      rst_n = 1'b1;
      check("rst_again", {sh_en, thr, t_ext}, 50'h0);
      rd_chk("stat_rst", CMD_STATUS_LOG, 256'h0);
      vin = 8'h33;
      e = 256'h1;
      for (int n = 0; n < 15; n++) begin
         e[16+16*n +: 16] = 16'hA533;
      end
      pulse(r_start);
      repeat (40) @(posedge clk) #1;
      rd_chk("ramp_new", CMD_RAMP_LOG, e);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Hang guard, well above the ~800 cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         n_errors++;
         final_report();
      end
   end
   initial begin
      {rst_n, r_start, r_good, ce} = 4'b0001;
      {vin, vout, st, r_cyc} = {16'h5AA5, 16'hC001, 32'd30};
      {vofs, trim} = {32'hAB12_34CD, 16'hF00D};
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      check("reset", {sh_en, thr, t_ext}, 50'h0);
      t_share();
      t_temp();
      t_trim();
      t_ramp();
      t_status();
      t_power();
      final_report();
   end
endmodule
